// ===== ssp_defs.svh
// constants for the software stack pointer instruction unit
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
// ***********************************
// opcode fields
// ***********************************
`define SSP_OP_SUB_HI 8'hE9
`define SSP_OP_PUSH_HI 8'hFA
`define SSP_OP_MOVE_HI 9'h1D7
`define SSP_OP_SECOND_HI 4'hF
`define SSP_SEL_SOFT 2'h2
`define SSP_SEL_RETURN 2'h3
// ***********************************
// special data addresses
// ***********************************
`define SSP_ADDR_PCL 12'hFF9
`define SSP_ADDR_RETURN_TOP_LOW_BYTE 12'hFFD
`define SSP_ADDR_RETURN_TOP_HIGH_BYTE 12'hFFE
`define SSP_ADDR_RETURN_TOP_UPPER_BYTE 12'hFFF
`define SSP_IND_LO 12'hFE1
`define SSP_IND_HI 12'hFEF
`define SSP_ZERO_BYTE 8'h00
`endif

// ===== ssp_pkg.sv
// types for the software stack pointer instruction unit
package ssp_pkg;
  typedef enum logic [1:0] {st_idle, st_ret_nop, st_move_src, st_move_dst} exec_state_e;
  typedef logic [11:0] addr_t;
  typedef logic [7:0] byte_t;
endpackage : ssp_pkg

// ===== soft_stack_pointer_instructions.sv
// execution unit for software stack pointer instructions
// Summary of operation
// (RL1) pointer subtract: selected pointer minus 6-bit literal
// (RL2) selector 11 means subtract-and-return on soft pointer
// (RL3) subtract-and-return then loads pc from return top
// (RL4) subtract-and-return: one word, two cycles, nop second
// (RL5) push literal at soft pointer, then decrement
// (RL6) move: addresses are soft pointer plus 7-bit offsets
// (RL7) indirect source reads zero; indirect destination is nop
// (RL8) software never targets pc low or return top
`timescale 1ns/1ns
`include "ssp_defs.svh"
module soft_stack_pointer_instructions (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cycle_en,
  input wire logic [15:0] instr_word,
  input wire ssp_pkg::byte_t mem_rdata,
  input wire logic [20:0] return_stack_top,
  output logic busy,
  output logic [11:0] indirect_pointer0,
  output logic [11:0] indirect_pointer1,
  output logic [11:0] soft_stack_pointer,
  output logic mem_we,
  output logic mem_re,
  output ssp_pkg::addr_t mem_addr,
  output ssp_pkg::byte_t mem_wdata,
  output logic pc_load,
  output logic [20:0] pc_value,
  output logic fetch_flush
);
  import ssp_pkg::*;

  // ***********************************
  // interface timing
  // ***********************************
  // an instruction is taken at a rising edge with cycle_en high and busy low
  // memory strobes, address and write data are combinational in that cycle
  // mem_rdata must settle in the same cycle; it is sampled at the edge
  // pointers change at the edge that takes the instruction
  // busy marks the second cycle of a return or a move; only that step runs
  // cheaper than a prefetch queue, at the cost of a long combinational path
  // from instr_word through the adder to mem_addr

  // ***********************************
  // decode helpers
  // ***********************************
  // true for the indirect access register window
  function automatic logic is_indirect(input addr_t a);
    is_indirect = (a >= `SSP_IND_LO) && (a <= `SSP_IND_HI) && (a[2:0] != 3'h0);
  endfunction : is_indirect

  // sequencer and datapath state
  exec_state_e state_q; // sequencer state
  logic [11:0] ptr_q [3]; // two indirect pointers and the soft stack pointer
  byte_t data_q; // byte captured from the source

  // opcode decode from the current program word
  wire logic is_sub = instr_word[15:8] == `SSP_OP_SUB_HI;
  wire logic is_push = instr_word[15:8] == `SSP_OP_PUSH_HI;
  wire logic is_move = instr_word[15:7] == `SSP_OP_MOVE_HI; // bit 7 clear is a different op
  wire logic [1:0] sel = instr_word[7:6];
  wire logic idle_go = cycle_en && state_q == st_idle;
  // source address of a move, computed from first word
  wire addr_t src_addr = soft_stack_pointer + {5'h00, instr_word[6:0]};
  // destination from the second word
  wire addr_t dst_addr = soft_stack_pointer + {5'h00, instr_word[6:0]}; // RL6
  // targets pc low and return top are never issued by software
  wire logic dst_bad = is_indirect(dst_addr); // RL7

  // pointer outputs straight from the flops
  assign indirect_pointer0 = ptr_q[0];
  assign indirect_pointer1 = ptr_q[1];
  assign soft_stack_pointer = ptr_q[2];
  assign busy = state_q != st_idle;

  // ***********************************
  // sequencer
  // ***********************************
  // moves wait for second word; returns spend a nop cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= st_idle;
    end else if (cycle_en) begin
      case (state_q)
        st_idle: begin
          if (is_sub && sel == `SSP_SEL_RETURN) begin
            state_q <= st_ret_nop; // RL4
          end else if (is_move) begin
            state_q <= st_move_dst;
          end
        end
        st_ret_nop: state_q <= st_idle; // RL4
        st_move_dst: state_q <= st_idle;
        default: state_q <= st_idle;
      endcase
    end
  end

  // ***********************************
  // pointer file
  // ***********************************
  // no status flag is touched by any of these ops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q[0] <= 12'h000;
      ptr_q[1] <= 12'h000;
      ptr_q[2] <= 12'h000;
    end else if (idle_go) begin
      if (is_sub && sel == `SSP_SEL_RETURN) begin
        ptr_q[2] <= ptr_q[2] - {6'h00, instr_word[5:0]}; // RL2
      end else if (is_sub) begin
        ptr_q[sel] <= ptr_q[sel] - {6'h00, instr_word[5:0]}; // RL1
      end else if (is_push) begin
        ptr_q[2] <= ptr_q[2] - 12'h001; // RL5
      end
    end
  end

  // ***********************************
  // move capture
  // ***********************************
  // source byte is taken in the first cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= 8'h00;
    end else if (idle_go && is_move) begin
      data_q <= is_indirect(src_addr) ? `SSP_ZERO_BYTE : mem_rdata; // RL7
    end
  end

  // ***********************************
  // memory and pc outputs
  // ***********************************
  // one strobe at most per cycle; all quiet otherwise
  always_comb begin
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_addr = 12'h000;
    mem_wdata = 8'h00;
    if (idle_go && is_push) begin
      mem_we = 1'b1; // RL5
      mem_addr = soft_stack_pointer;
      mem_wdata = instr_word[7:0];
    end else if (idle_go && is_move) begin
      mem_re = 1'b1; // RL6
      mem_addr = src_addr;
    end else if (cycle_en && state_q == st_move_dst && !dst_bad) begin
      mem_we = 1'b1; // RL6
      mem_addr = dst_addr;
      mem_wdata = data_q;
    end
  end

  // return happens at end of the first cycle
  assign pc_load = idle_go && is_sub && sel == `SSP_SEL_RETURN; // RL3
  assign pc_value = return_stack_top; // RL3
  assign fetch_flush = pc_load; // RL4

  // ***********************************
  // assertions
  // ***********************************
  // pointer 0 drops by the literal
  a_sub_ptr: assert property (@(posedge clk) disable iff (!reset_n) // RL1
    idle_go && is_sub && sel == 2'h0 |=> ptr_q[0] == $past(ptr_q[0]) - {6'h00, $past(instr_word[5:0])})
    else $error("pointer subtract wrong");
  // pointer 1 drops by the literal and pointer 0 is left alone
  a_sub_one: assert property (@(posedge clk) disable iff (!reset_n) // RL1
    idle_go && is_sub && sel == 2'h1 |=>
      ptr_q[1] == $past(ptr_q[1]) - {6'h00, $past(instr_word[5:0])} && $stable(ptr_q[0]))
    else $error("pointer one subtract wrong");
  // return works on the soft pointer only
  a_ret_soft: assert property (@(posedge clk) disable iff (!reset_n) // RL2
    pc_load |=> soft_stack_pointer == $past(soft_stack_pointer) - {6'h00, $past(instr_word[5:0])})
    else $error("return subtract wrong");
  // the other two pointers survive a return
  a_ret_keep: assert property (@(posedge clk) disable iff (!reset_n) // RL2
    pc_load |=> $stable(ptr_q[0]) && $stable(ptr_q[1]))
    else $error("return touched another pointer");
  // second cycle of a return does nothing
  a_ret_nop: assert property (@(posedge clk) disable iff (!reset_n) // RL4
    pc_load |=> busy && !mem_we && !pc_load)
    else $error("return second cycle not idle");
  // nothing leaves the unit in the nop cycle after the fetch is redirected
  a_nop_quiet: assert property (@(posedge clk) disable iff (!reset_n) // RL4
    state_q == st_ret_nop |-> !mem_we && !mem_re && !pc_load && !fetch_flush)
    else $error("activity in return nop cycle");
  // push writes at the pointer, then the pointer drops by one
  a_push_dec: assert property (@(posedge clk) disable iff (!reset_n) // RL5
    idle_go && is_push |-> mem_we && mem_addr == soft_stack_pointer ##1
      soft_stack_pointer == $past(mem_addr) - 12'h001)
    else $error("push wrong");
  // the pushed byte is the literal
  a_push_data: assert property (@(posedge clk) disable iff (!reset_n) // RL5
    idle_go && is_push |-> mem_wdata == instr_word[7:0])
    else $error("push data wrong");
  // indirect destination turns the move into a nop
  a_move_nop: assert property (@(posedge clk) disable iff (!reset_n) // RL7
    state_q == st_move_dst && is_indirect(dst_addr) |-> !mem_we)
    else $error("indirect destination written");
  // indirect source reads as zero
  a_src_zero: assert property (@(posedge clk) disable iff (!reset_n) // RL7
    idle_go && is_move && is_indirect(src_addr) |=> data_q == 8'h00)
    else $error("indirect source not zero");
  // plain source byte is carried to the second cycle
  a_src_copy: assert property (@(posedge clk) disable iff (!reset_n) // RL6
    idle_go && is_move && !is_indirect(src_addr) |=> data_q == $past(mem_rdata))
    else $error("source byte lost");
  // return loads pc from the return stack, only on its own encoding
  a_pc_from_top: assert property (@(posedge clk) disable iff (!reset_n) // RL3
    pc_load |-> instr_word[15:6] == 10'h3A7 && pc_value == return_stack_top && fetch_flush)
    else $error("return pc wrong");
  // move reads at soft pointer plus source offset
  a_move_addr: assert property (@(posedge clk) disable iff (!reset_n) // RL6
    idle_go && is_move |-> mem_re && mem_addr == soft_stack_pointer + {5'h00, instr_word[6:0]})
    else $error("move source address wrong");
  // move holds busy while it waits for its second word
  a_move_len: assert property (@(posedge clk) disable iff (!reset_n) // RL6
    idle_go && is_move |=> busy && state_q == st_move_dst)
    else $error("move length wrong");
  // the second word ends the move
  a_move_end: assert property (@(posedge clk) disable iff (!reset_n) // RL6
    state_q == st_move_dst && cycle_en |=> !busy)
    else $error("move did not end");
endmodule : soft_stack_pointer_instructions

// ===== testbench.sv
// self-checking bench for the software stack pointer instruction unit
`timescale 1ns/1ns
module testbench;
  import ssp_pkg::*;
  logic clk, reset_n, cycle_en, busy, mem_we, mem_re, pc_load, fetch_flush;
  logic [15:0] instr_word; // program word under execution
  byte_t mem_rdata, mem_wdata;
  addr_t mem_addr;
  logic [20:0] return_stack_top, pc_value;
  logic [11:0] ptr0, ptr1, sptr; // pointer outputs
  int err_total, check_count;
  soft_stack_pointer_instructions u_soft_stack_pointer_instructions (.clk(clk), .reset_n(reset_n),
    .cycle_en(cycle_en), .instr_word(instr_word), .mem_rdata(mem_rdata), .return_stack_top(return_stack_top),
    .busy(busy), .indirect_pointer0(ptr0), .indirect_pointer1(ptr1), .soft_stack_pointer(sptr),
    .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .pc_load(pc_load),
    .pc_value(pc_value), .fetch_flush(fetch_flush));
  // ****************
  // helpers
  // ****************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // inputs change at the falling edge, outputs settle 1 ns later
  task drive(input logic [15:0] w);
    @(negedge clk);
    instr_word = w;
    cycle_en = 1'b1;
    #1;
  endtask : drive
  task step();
    @(posedge clk);
    #1;
  endtask : step
  task idle();
    @(negedge clk);
    cycle_en = 1'b0;
  endtask : idle
  task results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // ****************
  // scenarios
  // ****************
  task t_subtract();
    drive(16'hE93F); step(); check("ptr0", ptr0, 12'hFC1);
    drive(16'hE941); step(); check("ptr1", ptr1, 12'hFFF);
    drive(16'hE9A3); check("pc_load", pc_load, 0); step(); check("sptr", sptr, 12'hFDD);
    check("ptr0 kept", ptr0, 12'hFC1);
    idle(); $display("subtract test done");
  endtask : t_subtract
  task t_push();
    drive(16'hFA08); check("we", mem_we, 1); check("addr", mem_addr, 12'hFDD);
    check("wdata", mem_wdata, 8'h08); step(); check("sptr", sptr, 12'hFDC);
    idle(); $display("push test done");
  endtask : t_push
  task t_return();
    return_stack_top = 21'h1_2345;
    drive(16'hE9E3); check("pc_load", pc_load, 1); check("flush", fetch_flush, 1);
    check("pc_value", pc_value, 21'h1_2345); step(); check("sptr", sptr, 12'hFB9);
    check("busy", busy, 1); check("ptr0 kept", ptr0, 12'hFC1);
    // a push offered in the nop cycle must be swallowed
    drive(16'hFA55); check("nop we", mem_we, 0); check("nop pc", pc_load, 0); step();
    check("busy end", busy, 0); check("sptr kept", sptr, 12'hFB9);
    idle(); $display("return test done");
  endtask : t_return
  task t_move(input logic [6:0] src, input logic [6:0] dst, input byte_t rd, input logic src_ind,
              input logic exp_we, input byte_t exp_data);
    mem_rdata = rd;
    drive({9'h1D7, src}); check("src addr", mem_addr, 12'hFB9 + src);
    if (!src_ind) check("re", mem_re, 1);
    step(); check("busy", busy, 1);
    drive({9'h1E0, dst}); check("dst we", mem_we, exp_we);
    if (exp_we) check("dst addr", mem_addr, 12'hFB9 + dst);
    if (exp_we) check("dst data", mem_wdata, exp_data);
    step(); check("busy end", busy, 0); check("sptr kept", sptr, 12'hFB9);
    idle(); $display("move test done");
  endtask : t_move
  task t_other();
    // neighbouring encodings must not start a move
    drive(16'hEB05);
    check("other re", mem_re, 0);
    check("other we", mem_we, 0);
    step();
    check("other busy", busy, 0);
    drive(16'hEA85);
    check("other2 re", mem_re, 0);
    step();
    check("other2 busy", busy, 0);
    check("other sptr kept", sptr, 12'hFB9);
    idle();
    $display("other opcode test done");
  endtask : t_other
  task t_reset();
    // reset in the middle of a move, then a push from a clean pointer
    drive({9'h1D7, 7'h01});
    step();
    check("busy before reset", busy, 1);
    @(negedge clk);
    cycle_en = 1'b0;
    reset_n = 1'b0;
    #1;
    check("mid reset busy", busy, 0);
    check("mid reset sptr", sptr, 12'h000);
    @(negedge clk);
    reset_n = 1'b1;
    drive(16'hFA77);
    check("push addr after reset", mem_addr, 12'h000);
    step();
    check("sptr after reset", sptr, 12'hFFF);
    idle();
    $display("reset test done");
  endtask : t_reset
  // ****************
  // main sequence
  // ****************
  initial begin
    reset_n = 1'b0; cycle_en = 1'b0; instr_word = 16'h0000; mem_rdata = 8'h00;
    return_stack_top = 21'h0_0000; err_total = 0; check_count = 0;
    repeat (4) @(posedge clk);
    @(negedge clk); reset_n = 1'b1; #1;
    check("reset sptr", sptr, 12'h000); check("reset busy", busy, 0);
    t_subtract(); t_push(); t_return();
    // move destinations stay clear of pc low and the return top bytes
    t_move(7'h05, 7'h06, 8'h33, 1'b0, 1'b1, 8'h33);
    t_move(7'h05, 7'h29, 8'h33, 1'b0, 1'b0, 8'h00);
    t_move(7'h28, 7'h06, 8'h5A, 1'b1, 1'b1, 8'h00);
    t_other();
    t_reset();
    results();
  end
  // hang guard
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    results();
  end
endmodule : testbench
